// file: core/rssd_pkg.sv
package rssd_pkg;

  localparam int unsigned DATA_W      = 16;
  localparam int unsigned WIDX_W      = 4;
  localparam int unsigned REP_W       = 14;
  localparam int unsigned LIT10_W     = 10;
  localparam int unsigned LIT5_W      = 5;
  localparam int unsigned RET_CYC     = 3;
  localparam int unsigned RET_CYC_RED = 2;
  localparam logic [1:0]  RET_CNT_W   = 2'h2;

  // status flags held by the core
  typedef struct packed {
    logic ovf;
    logic dcarry;
    logic neg;
    logic zero;
    logic carry;
  } rssd_flags_t;

  localparam rssd_flags_t FLAGS_RST = 5'h00;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_POWER_SAVE,
    OP_REPEAT_LIT,
    OP_REPEAT_REG,
    OP_IRQ_RETURN,
    OP_SUB_RETURN,
    OP_RETURN_LIT,
    OP_ROT_LEFT_CARRY,
    OP_ROT_LEFT_PLAIN,
    OP_ROT_RIGHT_CARRY,
    OP_ROT_RIGHT_PLAIN,
    OP_SIGN_EXTEND,
    OP_SHIFT_LEFT,
    OP_SHIFT_LEFT_CNT,
    OP_SUBTRACT,
    OP_SUBTRACT_BORROW,
    OP_REVERSE_SUBTRACT,
    OP_REVERSE_SUBTRACT_BORROW
  } rssd_op_t;

  // where a result goes
  typedef enum logic [1:0] {
    DST_FILE,
    DST_DEFAULT_DEFAULT_WORKING_REG,
    DST_DEFAULT_WORKING_REG
  } rssd_dst_t;

  // one decoded instruction from the decoder
  typedef struct packed {
    rssd_op_t        op;
    rssd_dst_t       dst;
    logic [WIDX_W-1:0] dst_idx;
    logic [DATA_W-1:0] opa;   // base / rotated operand
    logic [DATA_W-1:0] opb;   // subtrahend, count or literal
    logic            short_ret;
  } rssd_instr_t;

  // retired result
  typedef struct packed {
    logic              wr;
    rssd_dst_t         dst;
    logic [WIDX_W-1:0] dst_idx;
    logic [DATA_W-1:0] data;
  } rssd_result_t;

endpackage

// file: core/rssd_alu.sv
`timescale 1ns/1ps
`default_nettype none
// combinational arithmetic and rotate unit
module rssd_alu
  import rssd_pkg::*;
(
  input  wire rssd_op_t     op_i,
  input  wire logic [DATA_W-1:0] a_i,
  input  wire logic [DATA_W-1:0] b_i,
  input  wire rssd_flags_t  flags_i,
  output logic [DATA_W-1:0] res_o,
  output rssd_flags_t       flags_o
);

  logic [DATA_W:0]   diff;
  logic [4:0]        ndiff;
  logic [DATA_W-1:0] mnd;
  logic [DATA_W-1:0] sub;
  logic              bin;
  logic              is_sub;

  // reverse forms swap the operand roles; borrow forms take !carry
  assign is_sub = (op_i == OP_SUBTRACT) || (op_i == OP_SUBTRACT_BORROW) ||
                  (op_i == OP_REVERSE_SUBTRACT) || (op_i == OP_REVERSE_SUBTRACT_BORROW);
  assign mnd   = (op_i == OP_REVERSE_SUBTRACT || op_i == OP_REVERSE_SUBTRACT_BORROW) ? b_i : a_i;
  assign sub   = (op_i == OP_REVERSE_SUBTRACT || op_i == OP_REVERSE_SUBTRACT_BORROW) ? a_i : b_i;
  assign bin   = (op_i == OP_SUBTRACT_BORROW || op_i == OP_REVERSE_SUBTRACT_BORROW) ? ~flags_i.carry : 1'b0;
  assign diff  = {1'b0, mnd} + {1'b0, ~sub} + {{DATA_W{1'b0}}, ~bin};
  assign ndiff = {1'b0, mnd[3:0]} + {1'b0, ~sub[3:0]} + {4'h0, ~bin};

  // flags not written below hold their value
  always_comb
  begin
    res_o   = a_i;
    flags_o = flags_i;
    case (op_i)
      OP_ROT_LEFT_CARRY:
      begin
        res_o         = {a_i[DATA_W-2:0], flags_i.carry};
        flags_o.carry = a_i[DATA_W-1];
      end
      OP_ROT_LEFT_PLAIN:  res_o = {a_i[DATA_W-2:0], a_i[DATA_W-1]};
      OP_ROT_RIGHT_CARRY:
      begin
        res_o         = {flags_i.carry, a_i[DATA_W-1:1]};
        flags_o.carry = a_i[0];
      end
      OP_ROT_RIGHT_PLAIN: res_o = {a_i[0], a_i[DATA_W-1:1]};
      OP_SIGN_EXTEND:
      begin
        res_o         = {{8{a_i[7]}}, a_i[7:0]};
        flags_o.carry = ~a_i[7]; // carry is the inverted sign
      end
      OP_SHIFT_LEFT:
      begin
        res_o         = {a_i[DATA_W-2:0], 1'b0};
        flags_o.carry = a_i[DATA_W-1];
        flags_o.ovf   = a_i[DATA_W-1] ^ a_i[DATA_W-2];
      end
      OP_SHIFT_LEFT_CNT:  res_o = a_i << b_i[3:0];
      default:
      begin
        if (is_sub)
        begin
          res_o          = diff[DATA_W-1:0];
          flags_o.carry  = diff[DATA_W];   // 1 = no borrow
          flags_o.dcarry = ndiff[4];
          flags_o.ovf    = (mnd[DATA_W-1] ^ sub[DATA_W-1]) & (mnd[DATA_W-1] ^ diff[DATA_W-1]);
        end
      end
    endcase
    if (op_i inside {OP_ROT_LEFT_CARRY, OP_ROT_LEFT_PLAIN, OP_ROT_RIGHT_CARRY, OP_ROT_RIGHT_PLAIN,
                     OP_SIGN_EXTEND, OP_SHIFT_LEFT, OP_SHIFT_LEFT_CNT} || is_sub)
    begin
      flags_o.neg  = res_o[DATA_W-1];
      flags_o.zero = (res_o == '0);
    end
  end

endmodule
`default_nettype wire

// file: core/rssd_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module rssd_datapath
  import rssd_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic         issue_i,
  input  wire rssd_instr_t  instr_i,
  input  wire logic         watchdog_timeout_i,
  output logic              busy_o,
  output rssd_result_t      result_o,
  output rssd_flags_t       flags_o,
  output logic              sleep_o,
  output logic              idle_o,
  output logic              watchdog_timeout_flag_o,
  output logic              sleep_flag_o,
  output logic              repeat_active_o,
  output logic [REP_W-1:0]  repeat_left_o,
  output logic              return_pop_o
);

  typedef enum logic [0:0] {ST_RUN, ST_RET} rssd_state_t;

  rssd_state_t       state_reg, state_next;
  logic [1:0]        ret_cnt_reg;
  rssd_flags_t       flags_reg;
  rssd_flags_t       alu_flags;
  logic [DATA_W-1:0] alu_res;
  rssd_result_t      result_reg;
  logic              sleep_reg, idle_reg, watchdog_timeout_flag_reg, slpf_reg;
  logic [REP_W-1:0]  rep_reg;
  logic              rep_act_reg;
  logic              pop_reg;
  logic              take;
  logic              is_ret;
  logic              alu_op;
  // strobes below are gated by take, so a refused issue changes nothing
  logic              do_pwr;
  logic              do_rep_lit;
  logic              do_rep_reg;
  logic              do_ret_lit;
  logic              rep_step;
  logic              watchdog_timeout_flag_next;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign take   = issue_i && (state_reg == ST_RUN);
  assign is_ret = instr_i.op inside {OP_IRQ_RETURN, OP_SUB_RETURN, OP_RETURN_LIT};
  assign alu_op = !(instr_i.op inside {OP_NOP, OP_POWER_SAVE, OP_REPEAT_LIT, OP_REPEAT_REG,
                                       OP_IRQ_RETURN, OP_SUB_RETURN, OP_RETURN_LIT});
  assign busy_o = (state_reg != ST_RUN);

  // one strobe per sequencing action; keeping them as wires keeps the
  // clocked blocks short and the decode readable in one place
  assign do_pwr     = take && (instr_i.op == OP_POWER_SAVE);
  assign do_rep_lit = take && (instr_i.op == OP_REPEAT_LIT);
  assign do_rep_reg = take && (instr_i.op == OP_REPEAT_REG);
  assign do_ret_lit = take && (instr_i.op == OP_RETURN_LIT);
  assign rep_step   = take && rep_act_reg && (instr_i.op != OP_NOP);
  assign watchdog_timeout_flag_next  = watchdog_timeout_i | (watchdog_timeout_flag_reg & ~do_pwr); // set wins over the clear

  rssd_alu u_alu (
    .op_i    (instr_i.op),
    .a_i     (instr_i.opa),
    .b_i     (instr_i.opb),
    .flags_i (flags_reg),
    .res_o   (alu_res),
    .flags_o (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // return sequencing: stall the decoder for the extra cycles
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:  if (take && is_ret) state_next = ST_RET;
      ST_RET:  if (ret_cnt_reg == 2'h1) state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_reg   <= ST_RUN;
      ret_cnt_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      if (take && is_ret)
        ret_cnt_reg <= instr_i.short_ret ? 2'(RET_CYC_RED - 1) : 2'(RET_CYC - 1);
      else if (ret_cnt_reg != 2'h0)
        ret_cnt_reg <= ret_cnt_reg - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and result; non-alu ops leave flags alone
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      flags_reg  <= FLAGS_RST;
      result_reg <= '0;
    end
    else
    begin
      result_reg.wr <= 1'b0;
      if (take && alu_op)
      begin
        flags_reg           <= alu_flags;
        result_reg.wr       <= 1'b1;
        result_reg.dst      <= instr_i.dst;
        result_reg.dst_idx  <= instr_i.dst_idx;
        result_reg.data     <= alu_res;
      end
      else if (do_ret_lit)
      begin
        result_reg.wr      <= 1'b1;
        result_reg.dst     <= DST_DEFAULT_WORKING_REG;
        result_reg.dst_idx <= instr_i.dst_idx;
        result_reg.data    <= {{(DATA_W-LIT10_W){1'b0}}, instr_i.opb[LIT10_W-1:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power save; a wake is the core's job, here only reset or a power save of the other kind clears a level
  // limitation: sleep and idle stay up until reset or a power save of the other kind, the core must gate its clocks
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sleep_reg <= 1'b0;
      idle_reg  <= 1'b0;
      watchdog_timeout_flag_reg  <= 1'b0;
      slpf_reg  <= 1'b0;
    end
    else
    begin
      watchdog_timeout_flag_reg <= watchdog_timeout_flag_next;
      if (do_pwr)
      begin
        sleep_reg <= ~instr_i.opb[0];
        idle_reg  <= instr_i.opb[0];
        slpf_reg  <= ~instr_i.opb[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // repeat control; a nop does not use up a pass, so padding the pipe
  // cannot end a loop early
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rep_reg     <= '0;
      rep_act_reg <= 1'b0;
    end
    else if (do_rep_lit)
    begin
      rep_reg     <= instr_i.opb[REP_W-1:0];
      rep_act_reg <= 1'b1;
    end
    else if (do_rep_reg)
    begin
      rep_reg     <= instr_i.opa[REP_W-1:0];
      rep_act_reg <= 1'b1;
    end
    else if (rep_step)
    begin
      // each repeated pass counts down; the last pass runs at zero,
      // which gives count plus one passes in all
      if (rep_reg == '0)
        rep_act_reg <= 1'b0;
      else
        rep_reg <= rep_reg - {{(REP_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one pop pulse per taken return, so the stack unwinds exactly once
  // even though the return holds the decoder for extra cycles
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pop_reg <= 1'b0;
    else
      pop_reg <= take && is_ret;
  end

  assign result_o                = result_reg;
  assign flags_o                 = flags_reg;
  assign sleep_o                 = sleep_reg;
  assign idle_o                  = idle_reg;
  assign watchdog_timeout_flag_o = watchdog_timeout_flag_reg;
  assign sleep_flag_o            = slpf_reg;
  assign repeat_active_o         = rep_act_reg;
  assign repeat_left_o           = rep_reg;
  assign return_pop_o            = pop_reg;

endmodule
`default_nettype wire

// file: test/rssd_props.sv
`timescale 1ns/1ps
`default_nettype none
module rssd_props
  import rssd_pkg::*;
(
  input wire logic         mclk_i,
  input wire logic         rst_i,
  input wire logic         issue_i,
  input wire rssd_instr_t  instr_i,
  input wire logic         busy_o,
  input wire rssd_result_t result_o,
  input wire rssd_flags_t  flags_o,
  input wire logic         sleep_o,
  input wire logic         idle_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // an instruction only counts when the core is free to take it
  wire logic              tk = issue_i & ~busy_o;
  wire rssd_op_t          op = instr_i.op;
  wire logic [DATA_W-1:0] a  = instr_i.opa;

  rot_lc_a: assert property (tk && op == OP_ROT_LEFT_CARRY |=>
    result_o.data == {$past(a[14:0]), $past(flags_o.carry)} && flags_o.carry == $past(a[15])) else $error("rlc bad");
  rot_lp_a: assert property (tk && op == OP_ROT_LEFT_PLAIN |=>
    result_o.data == {$past(a[14:0]), $past(a[15])} && $stable(flags_o.carry)) else $error("rot_left_plain_op bad");
  rot_rc_a: assert property (tk && op == OP_ROT_RIGHT_CARRY |=>
    result_o.data == {$past(flags_o.carry), $past(a[15:1])} && flags_o.carry == $past(a[0])) else $error("rrc bad");
  rot_rp_a: assert property (tk && op == OP_ROT_RIGHT_PLAIN |=>
    result_o.data == {$past(a[0]), $past(a[15:1])} && $stable(flags_o.carry)) else $error("rot_right_plain_op bad");
  sign_ext_a: assert property (tk && op == OP_SIGN_EXTEND |=>
    result_o.data == {{8{$past(a[7])}}, $past(a[7:0])} && flags_o.carry == !$past(a[7])) else $error("se bad");
  shift_cnt_a: assert property (tk && op == OP_SHIFT_LEFT_CNT |=>
    result_o.data == ($past(a) << $past(instr_i.opb[3:0])) && $stable({flags_o.ovf, flags_o.carry}))
    else $error("sl count bad");
  sub_res_a: assert property (tk && op == OP_SUBTRACT |=>
    result_o.wr && result_o.data == $past(a) - $past(instr_i.opb)) else $error("sub bad");
  ret_long_a: assert property (tk && op == OP_IRQ_RETURN && !instr_i.short_ret |=>
    busy_o [*2] ##1 !busy_o) else $error("long return bad");
  ret_short_a: assert property (tk && op == OP_SUB_RETURN && instr_i.short_ret |=>
    busy_o ##1 !busy_o) else $error("short return bad");
  flag_keep_a: assert property (tk && op inside {OP_REPEAT_LIT, OP_REPEAT_REG} |=>
    $stable(flags_o)) else $error("repeat touched flags");
  pwr_save_a: assert property (tk && op == OP_POWER_SAVE |=>
    ($past(instr_i.opb[0]) ? idle_o : sleep_o)) else $error("power save bad");
  cover property (tk && op == OP_SUBTRACT_BORROW);
  cover property (tk && op == OP_IRQ_RETURN);
  cover property (tk && op == OP_POWER_SAVE);
endmodule

bind rssd_datapath rssd_props i_props (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .instr_i(instr_i),
  .busy_o(busy_o), .result_o(result_o), .flags_o(flags_o), .sleep_o(sleep_o), .idle_o(idle_o));
`default_nettype wire

// file: test/tb_rssd_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rssd_datapath
  import rssd_pkg::*;
;
  logic         mclk_i = 0;
  logic         rst_i  = 1;
  logic         issue_i = 0;
  logic         wdt    = 0;
  rssd_instr_t  instr  = '0;
  rssd_result_t res;
  rssd_flags_t  fl, ef;
  logic         busy, slp, idl, wdf, slf, rpa, pop;
  logic [13:0]  rpl;
  int           n_fail = 0;
  int           n_compared = 0;

  rssd_datapath i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .instr_i(instr),
    .watchdog_timeout_i(wdt), .busy_o(busy), .result_o(res), .flags_o(fl), .sleep_o(slp),
    .idle_o(idl), .watchdog_timeout_flag_o(wdf), .sleep_flag_o(slf), .repeat_active_o(rpa),
    .repeat_left_o(rpl), .return_pop_o(pop));

  // 40 MHz
  always #12.5 mclk_i = ~mclk_i;
  ////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic ck(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // inputs move on the falling edge so the rising edge never races them
  task automatic go(rssd_op_t o, logic [15:0] a, logic [15:0] b, logic sr = 0);
    @(negedge mclk_i);
    instr = '{o, DST_DEFAULT_WORKING_REG, 4'h3, a, b, sr};
    issue_i = 1;
    @(negedge mclk_i);
    issue_i = 0;
  endtask

  task automatic alu(rssd_op_t o, logic [15:0] a, logic [15:0] b, logic [15:0] er, rssd_flags_t f);
    go(o, a, b);
    ck("wr", 1, res.wr);
    ck("data", er, res.data);
    ck("dst idx", 16'h0003, res.dst_idx);
    ck("flags", f, fl);
    ef = f;
  endtask

  // carry set means no borrow; digit carry set means no borrow out of bit 3
  function automatic logic [20:0] sb(logic [15:0] a, logic [15:0] b, logic ci);
    logic [16:0] r;
    logic [4:0]  d;
    r = {1'b0, a} + {1'b0, ~b} + ci;
    d = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + ci;
    return {(a[15] != b[15]) && (r[15] != a[15]), d[4], r[15], r[15:0] == 0, r[16], r[15:0]};
  endfunction

  // flags not named by an instruction keep the previous expectation
  function automatic rssd_flags_t nz(logic [15:0] r, logic c);
    nz = ef;
    nz.neg = r[15];
    nz.zero = (r == 0);
    nz.carry = c;
  endfunction

  task automatic reset();
    @(negedge mclk_i);
    rst_i = 1;
    repeat (20) @(negedge mclk_i);
    rst_i = 0;
    ef = FLAGS_RST;
  endtask
  ////////////////////////////////////////
  task automatic t_sub();
    rssd_op_t    o[6] = '{OP_SUBTRACT, OP_SUBTRACT_BORROW, OP_SUBTRACT, OP_REVERSE_SUBTRACT_BORROW,
                          OP_REVERSE_SUBTRACT, OP_SUBTRACT_BORROW};
    logic [15:0] a[6] = '{16'h0003, 16'h8000, 16'h0005, 16'h0001, 16'h0010, 16'h0005};
    logic [15:0] b[6] = '{16'h0005, 16'h0001, 16'h0004, 16'h0002, 16'h0001, 16'h0005};
    logic [20:0] x;
    logic        ci;
    foreach (o[i])
    begin
      ci = (o[i] inside {OP_SUBTRACT_BORROW, OP_REVERSE_SUBTRACT_BORROW}) ? ef.carry : 1'b1;
      x = (o[i] inside {OP_REVERSE_SUBTRACT, OP_REVERSE_SUBTRACT_BORROW}) ? sb(b[i], a[i], ci) : sb(a[i], b[i], ci);
      alu(o[i], a[i], b[i], x[15:0], x[20:16]);
    end
  endtask

  task automatic t_rot();
    rssd_flags_t f;
    alu(OP_ROT_LEFT_CARRY, 16'h8001, 0, {15'h0001, ef.carry}, nz({15'h0001, ef.carry}, 1));
    alu(OP_ROT_LEFT_PLAIN, 16'h8001, 0, 16'h0003, nz(16'h0003, ef.carry));
    alu(OP_ROT_RIGHT_CARRY, 16'h0001, 0, {ef.carry, 15'h0000}, nz({ef.carry, 15'h0000}, 1));
    alu(OP_ROT_RIGHT_PLAIN, 16'h0000, 0, 16'h0000, nz(16'h0000, ef.carry));
    alu(OP_SIGN_EXTEND, 16'h1280, 0, 16'hFF80, nz(16'hFF80, 0));
    alu(OP_SIGN_EXTEND, 16'h007F, 0, 16'h007F, nz(16'h007F, 1));
    f = nz(16'h8000, 0);
    f.ovf = 1;
    alu(OP_SHIFT_LEFT, 16'h4000, 0, 16'h8000, f);
    alu(OP_SHIFT_LEFT_CNT, 16'h0F0F, 16'h0004, 16'hF0F0, nz(16'hF0F0, ef.carry));
  endtask

  // a request made while a return still holds the core must be ignored
  task automatic t_ret();
    go(OP_IRQ_RETURN, 0, 0);
    ck("pop", 1, pop);
    go(OP_SUBTRACT, 16'h0009, 16'h0001);
    ck("refused wr", 0, res.wr);
    ck("busy", 0, busy);
    go(OP_SUB_RETURN, 0, 0, 1);
    ck("short busy", 1, busy);
    @(negedge mclk_i);
    ck("short end", 0, busy);
    go(OP_RETURN_LIT, 0, 16'h03A5, 1);
    ck("lit", 16'h03A5, res.data);
    ck("ret flags", ef, fl);
  endtask

  task automatic t_ps();
    @(negedge mclk_i);
    wdt = 1;
    @(negedge mclk_i);
    wdt = 0;
    ck("wdt flag", 1, wdf);
    go(OP_POWER_SAVE, 0, 16'h0001);
    ck("idle", 1, idl);
    ck("wdt clr", 0, wdf);
    ck("idle no sleep flag", 0, slf);
    go(OP_REPEAT_REG, 16'h0000, 0);
    ck("rep on", 1, rpa);
    ck("rep left", 0, rpl);
    alu(OP_ROT_LEFT_PLAIN, 16'h0001, 0, 16'h0002, nz(16'h0002, ef.carry));
    ck("rep off", 0, rpa);
    go(OP_REPEAT_LIT, 0, 16'h3FFF);
    ck("rep lit", 1, rpa);
    ck("rep lit left", 16'h3FFF, rpl);
    ck("rep flags", ef, fl);
    reset();
    go(OP_POWER_SAVE, 0, 16'h0000);
    ck("sleep", 1, slp);
    ck("no idle", 0, idl);
    ck("sleep flag", 1, slf);
  endtask

  // main sequence
  initial
  begin
    reset();
    t_sub();
    t_rot();
    t_ret();
    t_ps();
    end_of_test();
  end

  // the tests need under a hundred cycles; this cuts a hang short
  initial
  begin
    #100us;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
